/* File: hw/rss_top.sv */
// reference source selector with priority list, holdover and apb registers
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module rss_top
  import rss_pkg::*;
#(
  parameter int          TICKS_PER_SEC = rss_pkg::SEC_CYCLES,
  parameter logic [15:0] HOLD_CONST    = rss_pkg::HCONST_RST
) (
  // clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        CE,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // reference availability pins, bit n-1 for source code n
  input  wire logic [5:0]  REF_AVAIL,
  // selection results
  output logic [2:0]       MASTER_SRC,
  output logic             MASTER_VALID,
  output logic [31:0]      APPLIED_OFFSET_NS,
  output logic             HOLD_PENDING,
  output logic [31:0]      HOLD_CALC_S,
  output logic [31:0]      HOLD_REMAIN_S,
  output logic             IRQ
);
  import rss_pkg::*;

  logic [5:0]       avail_m, avail_s, avail_prev;
  logic [2:0]       slot [NUM_SLOTS];
  logic [31:0]      ofs7 [7];
  logic [31:0]      prec7 [7];
  logic [15:0]      hconst;
  logic [IRQ_W-1:0] int_stat, int_en;
  rss_state_t       state, next_state;
  logic [2:0]       master_src, next_master_src;
  logic [2:0]       master_slot, next_master_slot;
  logic [31:0]      hold_calc, next_hold_calc;
  logic [31:0]      hold_remain, next_hold_remain;
  logic [31:0]      hold_elapsed, next_hold_elapsed;
  logic [31:0]      sec_cnt;
  logic             ev_switch, ev_lost;

  // availability pins come from other domains
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      avail_m    <= 6'h00;
      avail_s    <= 6'h00;
      avail_prev <= 6'h00;
    end else if (CE) begin
      avail_m    <= REF_AVAIL;
      avail_s    <= avail_m;
      avail_prev <= avail_s;
    end
  end

  wire [6:0] avail7      = {avail_s, 1'b0};
  wire       avail_chg   = avail_s != avail_prev;
  wire       master_avail = avail7[master_src];

  // apb decode
  wire        setup   = PSEL && !PENABLE;
  wire        access  = PSEL && PENABLE;
  wire [2:0]  idx     = PADDR[4:2];
  wire [2:0]  region  = PADDR[7:5];
  wire        hit_slot = region == ADDR_SLOT0[7:5] && idx < 3'(NUM_SLOTS);
  wire        hit_ofs  = region == ADDR_OFS1[7:5] && idx < 3'(NUM_SRC);
  wire        hit_prec = region == ADDR_PREC1[7:5] && idx < 3'(NUM_SRC);
  wire        hit_misc = region == ADDR_HCONST[7:5];
  wire        mapped   = PADDR[1:0] == 2'b00 && (hit_slot || hit_ofs || hit_prec || hit_misc);
  wire        wr       = access && PWRITE && mapped;
  wire [2:0]  src_idx  = idx + 3'h1;
  wire [6:0]  wr_slot  = (wr && hit_slot) ? 7'(1) << idx : 7'h00;
  wire [6:0]  wr_ofs   = (wr && hit_ofs) ? 7'(1) << src_idx : 7'h00;
  wire [6:0]  wr_prec  = (wr && hit_prec) ? 7'(1) << src_idx : 7'h00;
  wire        wr_hconst = wr && PADDR == ADDR_HCONST;
  wire        wr_clr    = wr && PADDR == ADDR_INT_CLR;
  wire        wr_en     = wr && PADDR == ADDR_INT_EN;

  assign PREADY = 1'b1;
  assign PSLVERR = access && !mapped;

  // per-slot and per-source configuration registers
  assign ofs7[0]  = OFS_RST;
  assign prec7[0] = PREC_RST;
  for (genvar i = 0; i < 7; i++) begin : g_cfg
    if (i < NUM_SLOTS) begin : g_slot
      always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) slot[i] <= SRC_NONE;
        else if (CE && wr_slot[i] && PWDATA[2:0] <= SRC_FREQ) slot[i] <= PWDATA[2:0];
      end
    end
    if (i == 32'(SRC_SAT)) begin : g_sat
      assign ofs7[i] = OFS_RST;
    end else if (i > 0) begin : g_ofs
      always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) ofs7[i] <= OFS_RST;
        else if (CE && wr_ofs[i]) ofs7[i] <= PWDATA;
      end
    end
    if (i > 0) begin : g_prec
      always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) prec7[i] <= PREC_RST;
        else if (CE && wr_prec[i]) prec7[i] <= PWDATA;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) hconst <= HOLD_CONST;
    else if (CE && wr_hconst) hconst <= PWDATA[15:0];
  end

  // selection helpers
  logic [3*NUM_SLOTS-1:0] slot_flat;
  logic                   found, immediate;
  logic [2:0]             best_slot, best_src;
  logic [31:0]            calc_q;

  for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_flat
    assign slot_flat[3*i +: 3] = slot[i];
  end
  rss_prio_pick #(.N(NUM_SLOTS)) u_pick (
    .slot_src  (slot_flat),
    .avail7    (avail7),
    .found     (found),
    .best_slot (best_slot),
    .best_src  (best_src)
  );
  rss_holdover_calc #(.PW(32), .CW(16)) u_calc (
    .prec_master (prec7[master_src]),
    .prec_next   (prec7[best_src]),
    .hconst      (hconst),
    .seconds     (calc_q),
    .immediate   (immediate)
  );

  wire tick = sec_cnt == 32'(TICKS_PER_SEC - 1);

  // selection state machine
  always_comb begin
    next_state        = state;
    next_master_src   = master_src;
    next_master_slot  = master_slot;
    next_hold_calc    = hold_calc;
    next_hold_remain  = hold_remain;
    next_hold_elapsed = hold_elapsed;
    ev_switch         = 1'b0;
    ev_lost           = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (found) begin
          next_state = ST_LOCKED;
          ev_switch  = 1'b1;
        end
      end
      ST_LOCKED: begin
        if (!master_avail) begin
          if (found && immediate) begin
            ev_switch = 1'b1;
          end else begin
            next_state        = ST_HOLD;
            next_hold_calc    = found ? calc_q : 32'h0000_0000;
            next_hold_remain  = found ? calc_q : 32'h0000_0000;
            next_hold_elapsed = 32'h0000_0000;
            ev_lost           = 1'b1;
          end
        end else if (found && best_slot < master_slot) begin
          ev_switch = 1'b1;
        end
      end
      ST_HOLD: begin
        if (master_avail) begin
          next_state       = ST_LOCKED;
          next_hold_remain = 32'h0000_0000;
        end else if (found && (immediate || hold_remain == 32'h0000_0000)) begin
          next_state       = ST_LOCKED;
          next_hold_remain = 32'h0000_0000;
          ev_switch        = 1'b1;
        end else if (avail_chg) begin
          next_hold_calc   = found ? calc_q : 32'h0000_0000;
          next_hold_remain = (found && calc_q > hold_elapsed) ? calc_q - hold_elapsed
                                                              : 32'h0000_0000;
        end else if (tick && hold_remain != 32'h0000_0000) begin
          next_hold_remain  = hold_remain - 32'h0000_0001;
          next_hold_elapsed = hold_elapsed + 32'h0000_0001;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (ev_switch) begin
      next_master_src  = best_src;
      next_master_slot = best_slot;
      next_state       = ST_LOCKED;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state        <= ST_IDLE;
      master_src   <= SRC_NONE;
      master_slot  <= 3'h7;
      hold_calc    <= 32'h0000_0000;
      hold_remain  <= 32'h0000_0000;
      hold_elapsed <= 32'h0000_0000;
    end else if (CE) begin
      state        <= next_state;
      master_src   <= next_master_src;
      master_slot  <= next_master_slot;
      hold_calc    <= next_hold_calc;
      hold_remain  <= next_hold_remain;
      hold_elapsed <= next_hold_elapsed;
    end
  end

  // second timer restarts on each holdover entry
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) sec_cnt <= 32'h0000_0000;
    else if (CE) sec_cnt <= (state != ST_HOLD || ev_lost || tick) ? 32'h0000_0000
                                                                   : sec_cnt + 32'h0000_0001;
  end

  // registered outputs
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      MASTER_VALID      <= 1'b0;
      APPLIED_OFFSET_NS <= OFS_RST;
    end else if (CE) begin
      MASTER_VALID      <= next_state != ST_IDLE;
      APPLIED_OFFSET_NS <= ofs7[next_master_src];
    end
  end

  assign MASTER_SRC    = master_src;
  assign HOLD_PENDING  = state == ST_HOLD;
  assign HOLD_CALC_S   = hold_calc;
  assign HOLD_REMAIN_S = hold_remain;

  // sticky events; a new event wins over a clear in the same cycle
  wire [IRQ_W-1:0] ev_vec = {avail_chg, ev_lost, ev_switch};
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      int_stat <= '0;
      int_en   <= '0;
    end else if (CE) begin
      int_stat <= (int_stat & ~(wr_clr ? PWDATA[IRQ_W-1:0] : '0)) | ev_vec;
      if (wr_en) int_en <= PWDATA[IRQ_W-1:0];
    end
  end
  assign IRQ = |(int_stat & int_en);

  // read data is captured in the setup cycle
  wire [31:0] misc_rd =
    PADDR == ADDR_HCONST   ? {16'h0000, hconst} :
    PADDR == ADDR_STATUS   ? {16'h0000, 2'b00, avail_s, 3'b000, master_src, 2'(state)} :
    PADDR == ADDR_HCALC    ? hold_calc :
    PADDR == ADDR_HREMAIN  ? hold_remain :
    PADDR == ADDR_MOFS     ? APPLIED_OFFSET_NS :
    PADDR == ADDR_INT_STAT ? 32'(int_stat) :
    PADDR == ADDR_INT_EN   ? 32'(int_en) : 32'h0000_0000;
  wire [31:0] rd_mux =
    !mapped  ? 32'h0000_0000 :
    hit_slot ? 32'(slot[idx]) :
    hit_ofs  ? ofs7[src_idx] :
    hit_prec ? prec7[src_idx] : misc_rd;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) PRDATA <= 32'h0000_0000;
    else if (CE && setup && !PWRITE) PRDATA <= rd_mux;
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N || !CE);
  sequence s_lost_slow;
    state == ST_LOCKED && !master_avail && found && !immediate;
  endsequence
  sequence s_hold_loaded;
    state == ST_HOLD && hold_calc == hold_remain && HOLD_PENDING;
  endsequence
  property p_prefer_best;
    state == ST_LOCKED && master_avail && found && best_slot < master_slot
      |=> master_src == $past(best_src) && MASTER_VALID;
  endproperty
  a_prefer_best: assert property (p_prefer_best) else $error("better source not taken");
  property p_sat_zero;
    MASTER_VALID && master_src == SRC_SAT && $past(master_src) == SRC_SAT
      |-> APPLIED_OFFSET_NS == 32'h0000_0000;
  endproperty
  a_sat_zero: assert property (p_sat_zero) else $error("satellite offset not zero");
  property p_ofs_applied;
    state != ST_IDLE && next_master_src == master_src
      |=> APPLIED_OFFSET_NS == $past(ofs7[master_src]);
  endproperty
  a_ofs_applied: assert property (p_ofs_applied) else $error("wrong offset applied");
  property p_immediate;
    state == ST_LOCKED && !master_avail && found && immediate
      |=> state == ST_LOCKED && master_src == $past(best_src);
  endproperty
  a_immediate: assert property (p_immediate) else $error("no instant switch");
  property p_hold_enter;
    s_lost_slow |=> s_hold_loaded and hold_calc == $past(calc_q);
  endproperty
  a_hold_enter: assert property (p_hold_enter) else $error("holdover not loaded");
  property p_countdown;
    state == ST_HOLD && !master_avail && !avail_chg && tick && !immediate
      && hold_remain != 32'h0000_0000 |=> hold_remain == $past(hold_remain) - 32'h0000_0001;
  endproperty
  a_countdown: assert property (p_countdown) else $error("remaining not decremented");
  property p_expire;
    state == ST_HOLD && !master_avail && found && hold_remain == 32'h0000_0000
      |=> state == ST_LOCKED && master_src == $past(best_src);
  endproperty
  a_expire: assert property (p_expire) else $error("no switch at expiry");
  property p_cancel;
    state == ST_HOLD && master_avail |=> state == ST_LOCKED && $stable(master_src);
  endproperty
  a_cancel: assert property (p_cancel) else $error("pending switch not cancelled");
  property p_recalc;
    state == ST_HOLD && !master_avail && avail_chg && found && !immediate
      && hold_remain != 32'h0000_0000 |=> hold_calc == $past(calc_q);
  endproperty
  a_recalc: assert property (p_recalc) else $error("holdover not recomputed");
  property p_report;
    HOLD_PENDING |-> HOLD_REMAIN_S <= HOLD_CALC_S;
  endproperty
  a_report: assert property (p_report) else $error("remaining exceeds calculated");
  property p_valid_src;
    MASTER_VALID |-> master_src != SRC_NONE && master_src <= SRC_FREQ;
  endproperty
  a_valid_src: assert property (p_valid_src) else $error("master source code illegal");

endmodule : rss_top

/* File: hw/rss_pkg.sv */
// shared constants and types for the reference source selector
package rss_pkg;

  localparam int NUM_SLOTS = 7;
  localparam int NUM_SRC   = 6;

  // source codes held in each priority slot
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_SAT  = 3'h1;
  localparam logic [2:0] SRC_PPS  = 3'h2;
  localparam logic [2:0] SRC_IRIG = 3'h3;
  localparam logic [2:0] SRC_NTP  = 3'h4;
  localparam logic [2:0] SRC_PTP  = 3'h5;
  localparam logic [2:0] SRC_FREQ = 3'h6;

  // register byte addresses
  localparam logic [7:0] ADDR_SLOT0    = 8'h00;
  localparam logic [7:0] ADDR_OFS1     = 8'h20;
  localparam logic [7:0] ADDR_PREC1    = 8'h40;
  localparam logic [7:0] ADDR_HCONST   = 8'h60;
  localparam logic [7:0] ADDR_STATUS   = 8'h64;
  localparam logic [7:0] ADDR_HCALC    = 8'h68;
  localparam logic [7:0] ADDR_HREMAIN  = 8'h6C;
  localparam logic [7:0] ADDR_MOFS     = 8'h70;
  localparam logic [7:0] ADDR_INT_STAT = 8'h74;
  localparam logic [7:0] ADDR_INT_CLR  = 8'h78;
  localparam logic [7:0] ADDR_INT_EN   = 8'h7C;

  // reset values, and the divisor for the constant held in tenths
  localparam logic [31:0] OFS_RST    = 32'h0000_0000;
  localparam logic [31:0] PREC_RST   = 32'h0000_0000;
  localparam logic [15:0] HCONST_RST = 16'h0072;
  localparam logic [15:0] HCONST_DIV = 16'h000A;

  // interrupt status bits
  localparam int IRQ_SWITCH = 0;
  localparam int IRQ_LOST   = 1;
  localparam int IRQ_CHANGE = 2;
  localparam int IRQ_W      = 3;

  // one second in clock cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int SEC_NS        = 1000000000;
  localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_LOCKED = 2'b01,
    ST_HOLD   = 2'b10
  } rss_state_t;

endpackage : rss_pkg

/* File: hw/rss_prio_pick.sv */
// picks the first assigned and available source in priority order
`timescale 1ns/10ps
module rss_prio_pick #(
  parameter int N = 7
) (
  // configuration and status
  input  wire logic [3*N-1:0] slot_src,
  input  wire logic [6:0]     avail7,
  // result
  output logic                found,
  output logic [2:0]          best_slot,
  output logic [2:0]          best_src
);
  import rss_pkg::*;

  // lowest slot index wins, so scan from the back
  always_comb begin
    found     = 1'b0;
    best_slot = 3'h0;
    best_src  = SRC_NONE;
    for (int i = N - 1; i >= 0; i--) begin
      if (slot_src[3*i +: 3] != SRC_NONE && avail7[slot_src[3*i +: 3]]) begin
        found     = 1'b1;
        best_slot = 3'(i);
        best_src  = slot_src[3*i +: 3];
      end
    end
  end

endmodule : rss_prio_pick

/* File: hw/rss_holdover_calc.sv */
// holdover seconds from the precisions of next and current reference
`timescale 1ns/10ps
module rss_holdover_calc #(
  parameter int PW = 32,
  parameter int CW = 16
) (
  // operands
  input  wire logic [PW-1:0] prec_master,
  input  wire logic [PW-1:0] prec_next,
  input  wire logic [CW-1:0] hconst,
  // result
  output logic [31:0]        seconds,
  output logic               immediate
);
  import rss_pkg::*;

  logic [PW+CW-1:0] num;
  logic [PW+CW-1:0] den;
  logic [PW+CW-1:0] quo;

  // constant is held in tenths, so scale the divisor by ten
  assign immediate = (prec_master == '0) || (prec_next == '0);
  assign num       = (PW+CW)'(prec_next) * (PW+CW)'(hconst);
  assign den       = (PW+CW)'(prec_master) * (PW+CW)'(HCONST_DIV);
  assign quo       = immediate ? '0 : num / den;
  // saturate rather than wrap on huge ratios
  assign seconds   = (quo > (PW+CW)'(32'hFFFF_FFFF)) ? 32'hFFFF_FFFF : quo[31:0];

endmodule : rss_holdover_calc

/* File: bench/rss_ref_model.sv */
// behavioural model of the external references driving the availability pins
`timescale 1ns/10ps
module rss_ref_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // wanted availability and settle lag in cycles
  input  wire logic [5:0] want,
  input  wire logic [7:0] lag,
  // availability pins
  output logic      [5:0] avail
);
  logic [7:0] cnt;

  // a slow receiver reports a change only after lag cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avail <= 6'h00;
      cnt   <= 8'h00;
    end else if (want == avail) begin
      cnt <= 8'h00;
    end else if (cnt >= lag) begin
      avail <= want;
      cnt   <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule : rss_ref_model

/* File: bench/rss_top_tb.sv */
// self-checking bench for the reference source selector
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
  $display("unexpected %s exp %h got %h", nm, ex, got); end end
module rss_top_tb;
  import rss_pkg::*;
  logic        clk     = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [5:0]  want    = 6'h00;
  logic [7:0]  lag     = 8'h00;
  logic [31:0] q;
  logic        e;
  int          err_total = 0;
  int          checked   = 0;
  int          cyc       = 0;
  wire logic [31:0] prdata;
  wire logic        pready;
  wire logic        pslverr;
  wire logic [5:0]  ref_avail;
  wire logic [2:0]  master_src;
  wire logic        master_valid;
  wire logic [31:0] ofs_ns;
  wire logic        hold_pending;
  wire logic [31:0] hold_calc;
  wire logic [31:0] hold_remain;
  wire logic        irq;

  always #5 clk = ~clk;

  rss_ref_model u_rss_ref_model (.clk(clk), .reset_n(reset_n), .want(want), .lag(lag),
    .avail(ref_avail));

  // short second keeps the long holdover countdown affordable
  rss_top #(.TICKS_PER_SEC(10)) u_rss_top (
    .CLK(clk), .RESET_N(reset_n), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .REF_AVAIL(ref_avail), .MASTER_SRC(master_src),
    .MASTER_VALID(master_valid), .APPLIED_OFFSET_NS(ofs_ns), .HOLD_PENDING(hold_pending),
    .HOLD_CALC_S(hold_calc), .HOLD_REMAIN_S(hold_remain), .IRQ(irq));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(nm, ex, q)
  endtask : rd

  task automatic wait_master(input logic [2:0] code, input int lim);
    int n;
    n = 0;
    while (master_src !== code && n < lim) begin
      n++;
      @(negedge clk);
    end
  endtask : wait_master

  task automatic wait_hold(input logic lvl, input int lim);
    int n;
    n = 0;
    while (hold_pending !== lvl && n < lim) begin
      n++;
      @(negedge clk);
    end
  endtask : wait_hold

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask : done

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    // reset values and refused accesses
    `CHK("master_valid", 1'b0, master_valid)
    rd("hconst", ADDR_HCONST, {16'h0000, HCONST_RST});
    for (int c = 1; c <= NUM_SRC; c++) begin
      rd("offset", ADDR_OFS1 + 8'(4 * (c - 1)), OFS_RST);
      rd("precision", ADDR_PREC1 + 8'(4 * (c - 1)), PREC_RST);
    end
    rd("unmapped", 8'h80, 32'h0000_0000);
    `CHK("pslverr", 1'b1, e)
    done("reset");
    // every source code fits a slot, an out-of-range one is refused
    for (int c = 1; c <= NUM_SRC; c++) begin
      wr(ADDR_SLOT0 + 8'h18, 32'(c));
      rd("slot6", ADDR_SLOT0 + 8'h18, 32'(c));
    end
    wr(ADDR_SLOT0 + 8'h18, 32'h0000_0000);
    wr(ADDR_SLOT0 + 8'h10, 32'h0000_0007);
    rd("slot4", ADDR_SLOT0 + 8'h10, 32'h0000_0000);
    // pps first, an empty slot, irig, then satellite
    wr(ADDR_SLOT0, {29'h0, SRC_PPS});
    wr(ADDR_SLOT0 + 8'h08, {29'h0, SRC_IRIG});
    wr(ADDR_SLOT0 + 8'h0C, {29'h0, SRC_SAT});
    rd("slot0", ADDR_SLOT0, {29'h0, SRC_PPS});
    wr(ADDR_PREC1 + 8'h04, 32'd100);
    wr(ADDR_PREC1 + 8'h08, 32'd10000);
    wr(ADDR_PREC1, 32'd20000);
    wr(ADDR_OFS1 + 8'h04, 32'd50);
    wr(ADDR_OFS1 + 8'h08, 32'd77);
    wr(ADDR_OFS1, 32'd5);
    rd("sat offset", ADDR_OFS1, 32'h0000_0000);
    done("config");
    // lower priority first, then the preferred one appears
    want <= 6'b000100;
    wait_master(SRC_IRIG, 20);
    `CHK("master", SRC_IRIG, master_src)
    `CHK("offset", 32'd77, ofs_ns)
    want <= 6'b000110;
    wait_master(SRC_PPS, 20);
    `CHK("master", SRC_PPS, master_src)
    rd("status", ADDR_STATUS, 32'h0000_0609);
    `CHK("offset", 32'd50, ofs_ns)
    `CHK("master_valid", 1'b1, master_valid)
    rd("mofs", ADDR_MOFS, 32'd50);
    done("select");
    // loss of master enters holdover and raises the interrupt
    wr(ADDR_INT_EN, 32'h0000_0007);
    wr(ADDR_INT_CLR, 32'h0000_0007);
    @(negedge clk);
    `CHK("irq", 1'b0, irq)
    want <= 6'b000100;
    wait_hold(1'b1, 10);
    `CHK("hold_calc", 32'd1140, hold_calc)
    rd("hcalc", ADDR_HCALC, 32'd1140);
    rd("hremain", ADDR_HREMAIN, 32'd1140);
    rd("int_lost", ADDR_INT_STAT, 32'h0000_0006);
    @(negedge clk);
    `CHK("irq", 1'b1, irq)
    wr(ADDR_INT_EN, 32'h0000_0000);
    @(negedge clk);
    `CHK("irq masked", 1'b0, irq)
    wr(ADDR_INT_EN, 32'h0000_0007);
    wr(ADDR_INT_CLR, 32'h0000_0007);
    rd("int_stat", ADDR_INT_STAT, 32'h0000_0000);
    repeat (35) @(negedge clk);
    `CHK("countdown", 1'b1, hold_remain < 32'd1140 && hold_remain > 32'd1125)
    // a slow receiver brings the master back before expiry
    lag  <= 8'd20;
    want <= 6'b000110;
    wait_hold(1'b0, 60);
    `CHK("hold_pending", 1'b0, hold_pending)
    `CHK("master", SRC_PPS, master_src)
    done("cancel");
    // availability change during holdover changes the figure
    lag  <= 8'd0;
    want <= 6'b000100;
    wait_hold(1'b1, 10);
    want <= 6'b000001;
    repeat (8) @(negedge clk);
    `CHK("hold_calc", 32'd2280, hold_calc)
    want <= 6'b000101;
    repeat (8) @(negedge clk);
    `CHK("hold_calc", 32'd1140, hold_calc)
    wait_master(SRC_IRIG, 12000);
    `CHK("master", SRC_IRIG, master_src)
    `CHK("hold_pending", 1'b0, hold_pending)
    done("expiry");
    // zero precision switches without holdover
    wr(ADDR_PREC1, 32'h0000_0000);
    want <= 6'b000001;
    wait_master(SRC_SAT, 8);
    `CHK("master", SRC_SAT, master_src)
    `CHK("hold_pending", 1'b0, hold_pending)
    @(negedge clk);
    `CHK("sat offset", 32'h0000_0000, ofs_ns)
    done("immediate");
    stop_test();
  end
endmodule : rss_top_tb
